// ==== hw/protect_map.vh ====
`ifndef PROTECT_MAP_VH
`define PROTECT_MAP_VH
// Clock rate in kHz (20 MHz)
`define CLK_KHZ 20000
// Delay figures in microseconds, nominal
`define OC_DET_US 1000000
`define OC_REL_US 16000
`define OD_DET_US 128000
`define OD_REL_US 1200
`define EDC_DET_US 12000
`define EDC_REL_US 1200
`define ECC_DET_US 8000
`define ECC_REL_US 1200
`define SHORT_DET_US 300
// Shortening divisor in test mode, at counter width so the quotient is not cut
`define SHORT_DIV 25'h3c
// Cycle counts of the nominal figures at 20 MHz; sized so no 32-bit product can overflow
`define OC_DET_CNT 25'h1312d00
`define OC_REL_CNT 25'h4e200
`define OD_DET_CNT 25'h271000
`define OD_REL_CNT 25'h5dc0
`define EDC_DET_CNT 25'h3a980
`define EDC_REL_CNT 25'h5dc0
`define ECC_DET_CNT 25'h27100
`define ECC_REL_CNT 25'h5dc0
`define SHORT_DET_CNT 25'h1770
`define CNT_W 25
`endif

// ==== hw/fault_timer.v ====
`default_nettype none
// Qualifies one condition: done only after it has held for limit cycles
module fault_timer #(
	parameter W = 25
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire cond_in,
	input wire [W-1:0] limit_in,
	output reg done_out
);
	reg [W-1:0] cnt_q;
	// Restart on any gap so only an uninterrupted interval counts
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_q <= {W{1'b0}};
			done_out <= 1'b0;
		end else if (!cond_in) begin
			cnt_q <= {W{1'b0}};
			done_out <= 1'b0;
		end else if (cnt_q + 1'b1 >= limit_in) begin
			done_out <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ==== hw/battery_protect_sequencer.v ====
`include "protect_map.vh"
`default_nettype none
// Function
// - Charge switch goes low after over-charge or excess charge current persists.
// - Discharge switch goes low after over-discharge or excess discharge current persists.
// - Over-charge detect delay nominally one second.
// - Over-charge release delay nominally sixteen milliseconds.
// - Over-discharge detect delay nominally 128 milliseconds.
// - Over-discharge release delay nominally 1.2 milliseconds.
// - Excess discharge current detect delay nominally twelve milliseconds.
// - Excess discharge current release delay nominally 1.2 milliseconds.
// - Excess charge current detect delay nominally eight milliseconds.
// - Excess charge current release delay nominally 1.2 milliseconds.
// - Short circuit drops discharge switch after nominally 300 microseconds.
// - Excess discharge or short fault clears once load disconnects.
// - Over-charge clears when charger removed, load present, voltage below threshold.
// - With charger kept connected, over-charge clears when voltage below threshold.
// - Over-discharge clears with charger connected and voltage above threshold.
// - Hysteresis variant needs voltage at or above separate release level.
// - After over-discharge, halt timers for minimum-current standby.
// - Test input with charge switch high shortens over-charge and over-discharge delays, about 1/60.
module battery_protect_sequencer #(
	parameter HYST_VARIANT = 1,
	parameter [24:0] OC_DET_CYC = `OC_DET_CNT,
	parameter [24:0] OC_REL_CYC = `OC_REL_CNT,
	parameter [24:0] OD_DET_CYC = `OD_DET_CNT,
	parameter [24:0] OD_REL_CYC = `OD_REL_CNT,
	parameter [24:0] EDC_DET_CYC = `EDC_DET_CNT,
	parameter [24:0] EDC_REL_CYC = `EDC_REL_CNT,
	parameter [24:0] ECC_DET_CYC = `ECC_DET_CNT,
	parameter [24:0] ECC_REL_CYC = `ECC_REL_CNT,
	parameter [24:0] SHORT_DET_CYC = `SHORT_DET_CNT
) (
	input wire clk_in,
	input wire arst_n_in,
	input wire upper_cell_overcharge_level_in,
	input wire lower_cell_overcharge_level_in,
	input wire upper_cell_overdischarge_level_in,
	input wire lower_cell_overdischarge_level_in,
	input wire overdischarge_release_level_in,
	input wire excess_discharge_current_in,
	input wire excess_charge_current_in,
	input wire short_circuit_in,
	input wire charger_present_in,
	input wire load_present_in,
	input wire delay_shorten_in,
	output reg charge_switch_out,
	output reg discharge_switch_out,
	output reg standby_out
);
	localparam W = `CNT_W;
	localparam NS = 10;
	////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for all comparator and sense inputs
	reg [NS-1:0] meta_q;
	reg [NS-1:0] sync_q;
	wire [NS-1:0] raw_w = {upper_cell_overcharge_level_in, lower_cell_overcharge_level_in,
		upper_cell_overdischarge_level_in, lower_cell_overdischarge_level_in,
		overdischarge_release_level_in, excess_discharge_current_in,
		excess_charge_current_in, short_circuit_in, charger_present_in, delay_shorten_in};
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			meta_q <= {NS{1'b0}};
			sync_q <= {NS{1'b0}};
		end else begin
			meta_q <= raw_w;
			sync_q <= meta_q;
		end
	end
	reg load_meta_q;
	reg load_q;
	// Load sense synchronised apart, idle level is load present
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			load_meta_q <= 1'b1;
			load_q <= 1'b1;
		end else begin
			load_meta_q <= load_present_in;
			load_q <= load_meta_q;
		end
	end
	wire oc_w = sync_q[9] | sync_q[8];
	wire od_w = sync_q[7] | sync_q[6];
	wire od_rel_lvl_w = sync_q[5];
	wire edc_w = sync_q[4];
	wire ecc_w = sync_q[3];
	wire short_w = sync_q[2];
	wire charger_w = sync_q[1];
	wire shorten_raw_w = sync_q[0];

	////////////////////////////////////////////////////////////////////
	// Fault state
	reg oc_q;
	reg od_q;
	reg edc_q;
	reg ecc_q;
	reg sc_q;
	// Test mode only while the charge switch is on
	wire shorten_w = shorten_raw_w & charge_switch_out;
	// Halt the detect timers and over-charge release timing once over-discharge latched
	wire halt_w = od_q;

	// Shortened limits, never below one cycle
	function [W-1:0] lim;
		input [W-1:0] nominal;
		input sh;
		reg [W-1:0] q;
		begin
			q = nominal / `SHORT_DIV;
			if (!sh)
				lim = nominal;
			else if (q == {W{1'b0}})
				lim = {{(W-1){1'b0}}, 1'b1};
			else
				lim = q;
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// Release conditions
	// Over-charge: voltage back below threshold, charger gone with load, or charger kept
	wire oc_rel_cond_w = oc_q & ~oc_w & ((~charger_w & load_q) | charger_w);
	// Over-discharge: charger present and voltage above the chosen release level
	wire od_above_w = HYST_VARIANT ? od_rel_lvl_w : ~od_w;
	wire od_rel_cond_w = od_q & charger_w & od_above_w;
	// Current faults: load removed clears discharge and short faults, charge current gone clears the charge fault
	wire edc_rel_cond_w = edc_q & ~load_q & ~edc_w;
	wire ecc_rel_cond_w = ecc_q & ~ecc_w;
	wire sc_rel_cond_w = sc_q & ~load_q;

	////////////////////////////////////////////////////////////////////
	// Timers, one instance per qualified condition
	wire oc_det_w;
	wire oc_rel_w;
	wire od_det_w;
	wire od_rel_w;
	wire edc_det_w;
	wire edc_rel_w;
	wire ecc_det_w;
	wire ecc_rel_w;
	wire sc_det_w;
	// Detect conditions; all but over-discharge stop while halted to save current
	wire oc_det_cond_w = oc_w & ~oc_q & ~halt_w;
	wire od_det_cond_w = od_w & ~od_q;
	wire edc_det_cond_w = edc_w & ~edc_q & ~halt_w;
	wire ecc_det_cond_w = ecc_w & ~ecc_q & ~halt_w;
	wire sc_det_cond_w = short_w & ~sc_q & ~halt_w;
	// Over-charge release timing also stops while halted
	wire oc_rel_run_w = oc_rel_cond_w & ~halt_w;
	// Limits of the two shortenable faults, picked afresh each cycle
	wire [W-1:0] oc_det_lim_w = lim(OC_DET_CYC, shorten_w);
	wire [W-1:0] oc_rel_lim_w = lim(OC_REL_CYC, shorten_w);
	wire [W-1:0] od_det_lim_w = lim(OD_DET_CYC, shorten_w);
	wire [W-1:0] od_rel_lim_w = lim(OD_REL_CYC, shorten_w);

	// Over-charge detect
	fault_timer #(
		.W(W)
	) t_oc_det (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(oc_det_cond_w),
		.limit_in(oc_det_lim_w),
		.done_out(oc_det_w)
	);

	// Over-charge release
	fault_timer #(
		.W(W)
	) t_oc_rel (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(oc_rel_run_w),
		.limit_in(oc_rel_lim_w),
		.done_out(oc_rel_w)
	);

	// Over-discharge detect
	fault_timer #(
		.W(W)
	) t_od_det (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(od_det_cond_w),
		.limit_in(od_det_lim_w),
		.done_out(od_det_w)
	);

	// Over-discharge release, left running in standby like the current-fault release timers
	fault_timer #(
		.W(W)
	) t_od_rel (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(od_rel_cond_w),
		.limit_in(od_rel_lim_w),
		.done_out(od_rel_w)
	);

	// Excess discharge current detect
	fault_timer #(
		.W(W)
	) t_edc_det (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(edc_det_cond_w),
		.limit_in(EDC_DET_CYC),
		.done_out(edc_det_w)
	);

	// Excess discharge current release
	fault_timer #(
		.W(W)
	) t_edc_rel (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(edc_rel_cond_w),
		.limit_in(EDC_REL_CYC),
		.done_out(edc_rel_w)
	);

	// Excess charge current detect
	fault_timer #(
		.W(W)
	) t_ecc_det (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(ecc_det_cond_w),
		.limit_in(ECC_DET_CYC),
		.done_out(ecc_det_w)
	);

	// Excess charge current release
	fault_timer #(
		.W(W)
	) t_ecc_rel (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(ecc_rel_cond_w),
		.limit_in(ECC_REL_CYC),
		.done_out(ecc_rel_w)
	);

	// Short circuit detect; its release needs no timer, only the load gone
	fault_timer #(
		.W(W)
	) t_sc_det (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.cond_in(sc_det_cond_w),
		.limit_in(SHORT_DET_CYC),
		.done_out(sc_det_w)
	);

	////////////////////////////////////////////////////////////////////
	// Fault flags: detect sets, qualified release clears; the short flag clears as soon as the load is gone
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			oc_q <= 1'b0;
			od_q <= 1'b0;
			edc_q <= 1'b0;
			ecc_q <= 1'b0;
			sc_q <= 1'b0;
		end else begin
			if (oc_det_w)
				oc_q <= 1'b1;
			else if (oc_rel_w)
				oc_q <= 1'b0;
			if (od_det_w)
				od_q <= 1'b1;
			else if (od_rel_w)
				od_q <= 1'b0;
			if (edc_det_w)
				edc_q <= 1'b1;
			else if (edc_rel_w)
				edc_q <= 1'b0;
			if (ecc_det_w)
				ecc_q <= 1'b1;
			else if (ecc_rel_w)
				ecc_q <= 1'b0;
			if (sc_det_w)
				sc_q <= 1'b1;
			else if (sc_rel_cond_w)
				sc_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Switch outputs, registered; high means switch on
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			charge_switch_out <= 1'b1;
			discharge_switch_out <= 1'b1;
			standby_out <= 1'b0;
		end else begin
			charge_switch_out <= ~(oc_q | ecc_q);
			discharge_switch_out <= ~(od_q | edc_q | sc_q);
			standby_out <= halt_w;
		end
	end
endmodule
`default_nettype wire

// ==== tb/cells_model.sv ====
`default_nettype none
// Far side: cells, charger and load; levels change only on the clock edge
module cells_model (
	input wire logic clk_in,
	input wire logic [6:0] flt_in,
	input wire logic chg_in,
	input wire logic load_in,
	input wire logic test_in,
	input wire logic sw_in,
	output var logic [10:0] lv_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Currents flow only through a connected load or charger, so faults vanish with them
	always @(posedge clk_in) begin
		lv_out[3:0] <= flt_in[3:0];
		lv_out[4] <= flt_in[4] & load_in;
		lv_out[5] <= flt_in[5] & chg_in;
		lv_out[6] <= flt_in[6] & load_in;
		lv_out[7] <= chg_in & ~|flt_in[3:2];
		lv_out[9:8] <= {load_in, chg_in};
		lv_out[10] <= test_in & sw_in;
	end
endmodule
`default_nettype wire

// ==== tb/protect_checker_assertions.sv ====
`default_nettype none
// Timing and cause checks seen from the top ports
module protect_checker #(
	parameter [24:0] ECC_DET_CYC = 25'h10,
	parameter [24:0] EDC_DET_CYC = 25'h18,
	parameter [24:0] SHORT_DET_CYC = 25'ha
) (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic upper_cell_overcharge_level_in,
	input wire logic lower_cell_overcharge_level_in,
	input wire logic upper_cell_overdischarge_level_in,
	input wire logic lower_cell_overdischarge_level_in,
	input wire logic excess_discharge_current_in,
	input wire logic excess_charge_current_in,
	input wire logic short_circuit_in,
	input wire logic charger_present_in,
	input wire logic load_present_in,
	input wire logic charge_switch_out,
	input wire logic discharge_switch_out,
	input wire logic standby_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ecc_q, edc_q, sc_q;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// Saturating run lengths of the charge current, discharge current and short faults, 2 sync + 2 flag and output + 2 spare cycles of slack
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ecc_q <= 8'h00;
			edc_q <= 8'h00;
			sc_q <= 8'h00;
		end else begin
			ecc_q <= excess_charge_current_in ? ecc_q + {7'h00, ecc_q != 8'hff} : 8'h00;
			edc_q <= excess_discharge_current_in ? edc_q + {7'h00, edc_q != 8'hff} : 8'h00;
			sc_q <= short_circuit_in ? sc_q + {7'h00, sc_q != 8'hff} : 8'h00;
		end
	end
	sequence ecc_held; ecc_q == ECC_DET_CYC + 6; endsequence
	sequence edc_held; edc_q == EDC_DET_CYC + 6; endsequence
	sequence sc_held; sc_q == SHORT_DET_CYC + 6; endsequence
	sequence sc_almost; sc_q == SHORT_DET_CYC - 1; endsequence
	a_ecc_detect: assert property (ecc_held |-> !charge_switch_out)
		else $error("charge switch still on after charge current fault");
	a_edc_detect: assert property (edc_held |-> !discharge_switch_out)
		else $error("discharge switch still on after discharge current fault");
	a_short_detect: assert property (sc_held |-> !discharge_switch_out)
		else $error("discharge switch still on after short");
	a_short_early: assert property (sc_almost |-> $stable(discharge_switch_out))
		else $error("discharge switch moved before short delay ran out");
	a_chg_fall_cause: assert property ($fell(charge_switch_out) |->
		$past(excess_charge_current_in | upper_cell_overcharge_level_in
		| lower_cell_overcharge_level_in, 5)) else $error("charge switch fell without cause");
	a_dis_fall_cause: assert property ($fell(discharge_switch_out) |->
		$past(excess_discharge_current_in | short_circuit_in | upper_cell_overdischarge_level_in
		| lower_cell_overdischarge_level_in, 5)) else $error("discharge switch fell without cause");
	a_chg_rise_cause: assert property ($rose(charge_switch_out) |->
		$past(!excess_charge_current_in || !(upper_cell_overcharge_level_in
		|| lower_cell_overcharge_level_in), 5))
		else $error("charge switch rose while every charge fault held");
	a_dis_rise_cause: assert property ($rose(discharge_switch_out) |->
		$past(charger_present_in || !load_present_in, 4)
		|| $past(charger_present_in || !load_present_in, 5))
		else $error("discharge switch rose with load on and no charger");
	a_standby_cause: assert property ($rose(standby_out) |-> !discharge_switch_out)
		else $error("standby without over-discharge");
endmodule
bind battery_protect_sequencer protect_checker #(.ECC_DET_CYC(ECC_DET_CYC),
	.EDC_DET_CYC(EDC_DET_CYC), .SHORT_DET_CYC(SHORT_DET_CYC)) chk (.*);
`default_nettype wire

// ==== tb/battery_protect_sequencer_tb.sv ====
`default_nettype none
module battery_protect_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
	logic clk_in = 1'b0, arst_n_in = 1'b0, chg = 1'b0, load = 1'b0, test = 1'b0;
	logic [6:0] flt = 7'h00;
	logic [1:0] q[$];
	logic [1:0] last = 2'b11, e;
	logic [15:0] r = 16'he520;
	wire [10:0] lv;
	wire chg_sw, dis_sw, stby;
	int num_errors = 0, tests_run = 0, i;
	cells_model far (.clk_in(clk_in), .flt_in(flt), .chg_in(chg), .load_in(load),
		.test_in(test), .sw_in(chg_sw), .lv_out(lv));
	// Short counts keep the run brief; expectations use the same figures
	battery_protect_sequencer #(.OC_DET_CYC(25'h78), .OC_REL_CYC(25'h14), .OD_DET_CYC(25'h1e),
		.OD_REL_CYC(25'hc), .EDC_DET_CYC(25'h18), .EDC_REL_CYC(25'hc), .ECC_DET_CYC(25'h10),
		.ECC_REL_CYC(25'hc), .SHORT_DET_CYC(25'ha)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.upper_cell_overcharge_level_in(lv[0]), .lower_cell_overcharge_level_in(lv[1]),
		.upper_cell_overdischarge_level_in(lv[2]), .lower_cell_overdischarge_level_in(lv[3]),
		.excess_discharge_current_in(lv[4]), .excess_charge_current_in(lv[5]),
		.short_circuit_in(lv[6]), .overdischarge_release_level_in(lv[7]),
		.charger_present_in(lv[8]), .load_present_in(lv[9]), .delay_shorten_in(lv[10]),
		.charge_switch_out(chg_sw), .discharge_switch_out(dis_sw), .standby_out(stby));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task step(input logic [6:0] f, input logic c, input logic l, input logic t, input int n);
		flt <= f;
		chg <= c;
		load <= l;
		test <= t;
		repeat (n) @(posedge clk_in);
	endtask
	task final_report;
		`CHK(q.size(), 0)
		$display("errors=%0d checks=%0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #25 clk_in = ~clk_in;
	// Any switch change takes the oldest note; an unnoted change is a mismatch
	always @(negedge clk_in) begin
		if (arst_n_in && {chg_sw, dis_sw} !== last) begin
			last = {chg_sw, dis_sw};
			e = q.size() ? q.pop_front() : 2'bxx;
			`CHK(last, e)
		end
	end
	// Hang guard well beyond the longest sequence
	initial begin
		#4000000;
		num_errors++;
		final_report;
	end
	initial begin
		repeat (8) @(posedge clk_in);
		arst_n_in <= 1'b1;
		@(posedge clk_in);
		q.push_back(2'b01);
		step(7'h20, 1, 0, 0, 150);
		q.push_back(2'b11);
		step(7'h00, 1, 0, 0, 150);
		// Upper cell released with charger gone and load on, lower with charger kept
		for (i = 0; i < 2; i++) begin
			q.push_back(2'b01);
			step(7'h01 << i, 1, 0, 0, 150);
			q.push_back(2'b11);
			step(7'h00, i[0], 1, 0, 150);
		end
		// A short pulse shorter than its delay must leave the switch alone
		r = lfsr(r);
		step(7'h40, 0, 1, 0, 1 + r % 7);
		step(7'h00, 0, 1, 0, 40);
		// Random bursts, each shorter than any delay and split by gaps, must move nothing
		for (i = 0; i < 16; i++) begin
			r = lfsr(r);
			step(r[6:0], r[7], r[8], 0, 1 + r[11:9] % 7);
			step(7'h00, r[7], r[8], 0, 4);
		end
		`CHK({chg_sw, dis_sw}, 2'b11)
		for (i = 0; i < 2; i++) begin
			q.push_back(2'b10);
			step(i ? 7'h10 : 7'h40, 0, 1, 0, 150);
			q.push_back(2'b11);
			step(7'h00, 0, 0, 0, 150);
		end
		q.push_back(2'b10);
		step(7'h04, 0, 0, 0, 150);
		`CHK(stby, 1'b1)
		q.push_back(2'b11);
		step(7'h00, 1, 0, 0, 150);
		// Twelve cycles is far below the normal over-charge delay
		q.push_back(2'b01);
		step(7'h01, 1, 0, 1, 12);
		`CHK(chg_sw, 1'b0)
		q.push_back(2'b11);
		step(7'h00, 1, 0, 0, 150);
		final_report;
	end
endmodule
`default_nettype wire
